// ==== rtl/rbf_pkg.sv ====
// Shared constants for the block memory ROM and FIFO modes
package rbf_pkg;
    localparam int RBF_DATA_W = 8;
    localparam int RBF_ROM_AW = 8;
    localparam int RBF_FIFO_AW = 4;
    localparam int RBF_SYNC_STAGES = 2;
    localparam bit RBF_ROM_OUT_REG = 1'b1;
    localparam bit RBF_DUAL_CLOCK = 1'b0;
    localparam logic [RBF_DATA_W-1:0] RBF_ROM_SEED = 8'hA5;
    localparam logic [RBF_DATA_W-1:0] RBF_DATA_RST = 8'h00;
    localparam logic RBF_EMPTY_RST = 1'b1;
    localparam logic RBF_FULL_RST = 1'b0;
    typedef enum logic [2:0] {
        RBF_SK_NONE = 3'b001,
        RBF_SK_ONE = 3'b010,
        RBF_SK_TWO = 3'b100
    } rbf_skid_state_t;
endpackage : rbf_pkg

// ==== rtl/rbf_skid.sv ====
// Two-entry output buffer between FIFO storage and the reader
`timescale 1ns/10ps
module rbf_skid #(
    parameter int DW = rbf_pkg::RBF_DATA_W
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [DW-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [DW-1:0] out_data
);
    import rbf_pkg::*;

    rbf_skid_state_t state;
    logic [DW-1:0] spare;
    logic push;
    logic pop;

    // Ready depends only on state, so a stalled reader stalls the FIFO
    assign in_ready = (state != RBF_SK_TWO);
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= RBF_SK_NONE;
        end else begin
            case (state)
                RBF_SK_NONE: begin
                    if (push) begin
                        state <= RBF_SK_ONE;
                    end
                end
                RBF_SK_ONE: begin
                    if (push && !pop) begin
                        state <= RBF_SK_TWO;
                    end else if (pop && !push) begin
                        state <= RBF_SK_NONE;
                    end
                end
                RBF_SK_TWO: begin
                    if (pop) begin
                        state <= RBF_SK_ONE;
                    end
                end
                default: begin
                    state <= RBF_SK_NONE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_data <= RBF_DATA_RST;
            spare <= RBF_DATA_RST;
        end else begin
            if (state == RBF_SK_TWO) begin
                if (pop) begin
                    out_data <= spare;
                end
            end else if (!out_valid || pop) begin
                out_valid <= push;
                if (push) begin
                    out_data <= in_data;
                end
            end else if (push) begin
                spare <= in_data;
            end
        end
    end
endmodule : rbf_skid

// ==== rtl/rbf_top.sv ====
// Block memory in ROM mode and in FIFO mode
//
// Functional notes
// - ROM holds fixed contents set at build
// - ROM read address is registered first when ROM_OUT_REG is set
// - Build option: address register plus output register, or output register only
// - ROM read behaves as single-port RAM read
// - FIFO offers shared-clock or crossing-style pointer paths
`timescale 1ns/10ps
module rbf_top #(
    parameter int DW = rbf_pkg::RBF_DATA_W,
    parameter int ROM_AW = rbf_pkg::RBF_ROM_AW,
    parameter int FIFO_AW = rbf_pkg::RBF_FIFO_AW,
    parameter bit ROM_OUT_REG = rbf_pkg::RBF_ROM_OUT_REG,
    parameter bit DUAL_CLOCK = rbf_pkg::RBF_DUAL_CLOCK,
    parameter logic [DW-1:0] ROM_SEED = rbf_pkg::RBF_ROM_SEED
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic rom_rd_en,
    input wire logic [ROM_AW-1:0] rom_addr,
    output logic [DW-1:0] rom_data,
    input wire logic wr_valid,
    input wire logic [DW-1:0] wr_data,
    output logic wr_ready,
    output logic fifo_full,
    output logic fifo_empty,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [DW-1:0] rd_data
);
    import rbf_pkg::*;

    localparam int ROM_DEPTH = 1 << ROM_AW;
    localparam int FIFO_DEPTH = 1 << FIFO_AW;

    // ROM storage
    logic [DW-1:0] rom [ROM_DEPTH];
    logic [ROM_AW-1:0] rom_addr_q;
    logic rom_en_q;

    // fixed contents
    // Contents are a constant table; nothing in normal operation writes it
    for (genvar i = 0; i < ROM_DEPTH; i++) begin : g_rom
        assign rom[i] = DW'(i) ^ ROM_SEED;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rom_addr_q <= '0;
            rom_en_q <= 1'b0;
        end else begin
            rom_en_q <= rom_rd_en;
            if (rom_rd_en) begin
                rom_addr_q <= rom_addr;
            end
        end
    end

    // single-port read timing
    // Direct mode merges address register and lookup to keep a flop on the pin
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rom_data <= RBF_DATA_RST;
        end else if (ROM_OUT_REG) begin
            if (rom_en_q) begin
                rom_data <= rom[rom_addr_q];
            end
        end else if (rom_rd_en) begin
            rom_data <= rom[rom_addr];
        end
    end

    // FIFO storage and pointers, one extra bit for wrap
    logic [DW-1:0] mem [FIFO_DEPTH];
    logic [FIFO_AW:0] wr_bin;
    logic [FIFO_AW:0] rd_bin;
    logic [FIFO_AW:0] wr_gray;
    logic [FIFO_AW:0] rd_gray;
    logic [FIFO_AW:0] next_wr_bin;
    logic [FIFO_AW:0] next_rd_bin;
    logic [FIFO_AW:0] next_wr_gray;
    logic [FIFO_AW:0] next_rd_gray;
    logic [FIFO_AW:0] wr_seen;
    logic [FIFO_AW:0] rd_seen;
    logic [FIFO_AW:0] wr_sync [RBF_SYNC_STAGES];
    logic [FIFO_AW:0] rd_sync [RBF_SYNC_STAGES];
    logic do_write;
    logic do_read;
    logic skid_ready;
    logic empty_q;

    assign do_write = wr_valid & wr_ready;
    // reads while empty are not issued
    // a word written to an empty FIFO is readable two cycles after its write cycle with shared-clock pointers, four with crossing style
    assign do_read = !empty_q & skid_ready;

    assign next_wr_bin = wr_bin + (FIFO_AW + 1)'(do_write);
    assign next_rd_bin = rd_bin + (FIFO_AW + 1)'(do_read);
    assign next_wr_gray = next_wr_bin ^ (next_wr_bin >> 1);
    assign next_rd_gray = next_rd_bin ^ (next_rd_bin >> 1);

    // clocking choice
    // Crossing style sees the far pointer late, so flags stay safe but lag
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int s = 0; s < RBF_SYNC_STAGES; s++) begin
                wr_sync[s] <= '0;
                rd_sync[s] <= '0;
            end
        end else begin
            wr_sync[0] <= wr_gray;
            rd_sync[0] <= rd_gray;
            for (int s = 1; s < RBF_SYNC_STAGES; s++) begin
                wr_sync[s] <= wr_sync[s-1];
                rd_sync[s] <= rd_sync[s-1];
            end
        end
    end

    assign wr_seen = DUAL_CLOCK ? wr_sync[RBF_SYNC_STAGES-1] : wr_gray;
    assign rd_seen = DUAL_CLOCK ? rd_sync[RBF_SYNC_STAGES-1] : rd_gray;

    always_ff @(posedge sys_clk) begin
        if (do_write) begin
            mem[wr_bin[FIFO_AW-1:0]] <= wr_data;
        end
    end

    // full flag from next write pointer
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wr_bin <= '0;
            wr_gray <= '0;
            fifo_full <= RBF_FULL_RST;
            wr_ready <= !RBF_FULL_RST;
        end else begin
            wr_bin <= next_wr_bin;
            wr_gray <= next_wr_gray;
            fifo_full <= (next_wr_gray == {~rd_seen[FIFO_AW:FIFO_AW-1],
                rd_seen[FIFO_AW-2:0]});
            wr_ready <= (next_wr_gray != {~rd_seen[FIFO_AW:FIFO_AW-1],
                rd_seen[FIFO_AW-2:0]});
        end
    end

    // empty flag from next read pointer
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rd_bin <= '0;
            rd_gray <= '0;
            empty_q <= RBF_EMPTY_RST;
            fifo_empty <= RBF_EMPTY_RST;
        end else begin
            rd_bin <= next_rd_bin;
            rd_gray <= next_rd_gray;
            empty_q <= (next_rd_gray == wr_seen);
            fifo_empty <= (next_rd_gray == wr_seen);
        end
    end

    rbf_skid #(
        .DW(DW)
    ) u_skid (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(do_read),
        .in_ready(skid_ready),
        .in_data(mem[rd_bin[FIFO_AW-1:0]]),
        .out_valid(rd_valid),
        .out_ready(rd_ready),
        .out_data(rd_data)
    );
endmodule : rbf_top

// ==== sim/rbf_top_assertions.sv ====
// Port checker for the block memory ROM and FIFO
`timescale 1ns/10ps
module rbf_checker #(
    parameter int DW = rbf_pkg::RBF_DATA_W,
    parameter int ROM_AW = rbf_pkg::RBF_ROM_AW,
    parameter logic [DW-1:0] ROM_SEED = rbf_pkg::RBF_ROM_SEED
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic rom_rd_en,
    input wire logic [ROM_AW-1:0] rom_addr,
    input wire logic [DW-1:0] rom_data,
    input wire logic wr_valid,
    input wire logic [DW-1:0] wr_data,
    input wire logic wr_ready,
    input wire logic fifo_full,
    input wire logic fifo_empty,
    input wire logic rd_valid,
    input wire logic rd_ready,
    input wire logic [DW-1:0] rd_data
);
    import rbf_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    rom_latency_a: assert property (
        rom_rd_en |-> ##2 rom_data == ($past(rom_addr, 2) ^ ROM_SEED))
        else $error("rom word late or wrong");
    rom_fixed_a: assert property (
        !$past(rom_rd_en, 2) |-> $stable(rom_data)) else $error("rom word changed unread");
    full_ready_a: assert property (
        fifo_full == !wr_ready) else $error("full and ready disagree");
    first_word_a: assert property (
        fifo_empty && !rd_valid && wr_valid && wr_ready |=> ##1 !fifo_empty ##1 rd_valid)
        else $error("first word not delivered");
    no_phantom_a: assert property (
        fifo_empty && !rd_valid && !wr_valid |=> !rd_valid) else $error("word from nothing");
    out_hold_a: assert property (
        rd_valid && !rd_ready |=> rd_valid && $stable(rd_data)) else $error("word lost on stall");
endmodule : rbf_checker

bind rbf_top rbf_checker #(.DW(DW), .ROM_AW(ROM_AW), .ROM_SEED(ROM_SEED)) rbf_checker_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .rom_rd_en(rom_rd_en), .rom_addr(rom_addr),
    .rom_data(rom_data), .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready),
    .fifo_full(fifo_full), .fifo_empty(fifo_empty), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data));

// ==== sim/rbf_reader.sv ====
// Reader model that takes FIFO words with chosen stalls
`timescale 1ns/10ps
module rbf_reader (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [1:0] mode,
    input wire logic rd_valid,
    output logic rd_ready = 1'b0
);
    always @(posedge sys_clk) begin
        #1;
        rd_ready <= rst_n && rd_valid && (mode == 0 || (mode == 2 && $urandom_range(1) == 1));
    end
endmodule : rbf_reader

// ==== sim/test_rbf_top.sv ====
// Self-checking bench for the block memory ROM and FIFO
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; $display("wrong value %s exp %h got %h", n, e, g); end end
module test_rbf_top;
    import rbf_pkg::*;
    logic sys_clk = 0, rst_n = 0, rom_rd_en = 0, wr_valid = 0;
    logic rd_ready, fifo_full, fifo_empty, wr_ready, rd_valid;
    logic [RBF_ROM_AW-1:0] rom_addr = 0;
    logic [RBF_DATA_W-1:0] wr_data = 0, rom_data, rd_data, e, f;
    logic [RBF_DATA_W-1:0] rq[$], fq[$];
    logic [1:0] mode = 0, rp = 0;
    int n_mismatch = 0, samples_checked = 0, n;
    bit ok;
    always #5 sys_clk = ~sys_clk;
    rbf_top rbf_top_inst (.sys_clk(sys_clk), .rst_n(rst_n), .rom_rd_en(rom_rd_en),
        .rom_addr(rom_addr), .rom_data(rom_data), .wr_valid(wr_valid), .wr_data(wr_data),
        .wr_ready(wr_ready), .fifo_full(fifo_full), .fifo_empty(fifo_empty),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));
    rbf_reader rbf_reader_inst (.sys_clk(sys_clk), .rst_n(rst_n), .mode(mode),
        .rd_valid(rd_valid), .rd_ready(rd_ready));
    always @(posedge sys_clk) rp <= {rp[0], rom_rd_en};
    always @(negedge sys_clk) if (rp[1]) begin
        e = rq.pop_front();
        `CHK("rom_data", e, rom_data)
    end
    always @(posedge sys_clk) if (rd_valid && rd_ready) begin
        f = fq.pop_front();
        `CHK("rd_data", f, rd_data)
    end
    task wrap_up;
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    // Word is noted only when ready was seen before the edge, so refusals store nothing
    task put(input logic [RBF_DATA_W-1:0] d, input int tries);
        ok = 0;
        wr_valid <= 1;
        wr_data <= d;
        repeat (tries) if (!ok) begin
            ok = wr_ready;
            if (ok) fq.push_back(d);
            @(posedge sys_clk);
            #1;
        end
    endtask : put
    initial begin
        #100000;
        n_mismatch++;
        wrap_up;
    end
    initial begin
        void'($urandom(66154));
        repeat (10) @(posedge sys_clk);
        #1 rst_n <= 1;
        @(posedge sys_clk);
        #1;
        repeat (40) begin
            n = $urandom;
            rom_addr <= n[RBF_ROM_AW-1:0];
            rom_rd_en <= n[8];
            if (n[8]) rq.push_back(n[RBF_ROM_AW-1:0] ^ RBF_ROM_SEED);
            @(posedge sys_clk);
            #1;
        end
        rom_rd_en <= 0;
        mode = 1;
        n = 0;
        repeat (20) begin
            put(n[RBF_DATA_W-1:0], 1);
            n += ok;
        end
        wr_valid <= 0;
        `CHK("accepted", 18, n)
        `CHK("fifo_full", 1'b1, fifo_full)
        mode = 0;
        repeat (30) @(posedge sys_clk);
        #1;
        `CHK("fifo_empty", 1'b1, fifo_empty)
        `CHK("rd_valid", 1'b0, rd_valid)
        mode = 2;
        repeat (60) put(RBF_DATA_W'($urandom), 60);
        wr_valid <= 0;
        mode = 0;
        repeat (30) @(posedge sys_clk);
        `CHK("left over", 0, fq.size())
        wrap_up;
    end
endmodule : test_rbf_top
